// ### common/ekci_regs.svh
/*
  Constants for the entry keyboard channel interface: input word bit positions,
  function key codes, timing and reset values.
  Assumes inclusion by bare name from files that need the constants.
*/
`ifndef EKCI_REGS_SVH
`define EKCI_REGS_SVH

`define EKCI_CODE_LSB 1
`define EKCI_CODE_MSB 7
`define EKCI_REPEAT_BIT 9
`define EKCI_INHIBIT_BIT 10
`define EKCI_STROBE_BIT 11
`define EKCI_PROTECT_BIT 12
`define EKCI_ALARM_DIS_BIT 13
`define EKCI_RPT_CMD_BIT 14
`define EKCI_WORD_RESET 16'h0000
`define EKCI_CHAR_LO 7'h20
`define EKCI_CHAR_HI 7'h5f
`define EKCI_KEY_CLEAR 7'h00
`define EKCI_KEY_INTERRUPT 7'h02
`define EKCI_KEY_LINE_CLEAR 7'h03
`define EKCI_KEY_NEW_LINE 7'h0a
`define EKCI_KEY_MARK_RESET 7'h1c
`define EKCI_CLK_HZ 40000000
`define EKCI_REPEAT_MS 500
`define EKCI_REPEAT_CYC ((`EKCI_CLK_HZ / 1000) * `EKCI_REPEAT_MS)
`define EKCI_FIFO_DEPTH 32

`endif

// ### common/ekci_pkg.sv
/*
  Types for the entry keyboard channel interface.
  Assumes ekci_regs.svh is on the include path.
*/
package ekci_pkg;
  typedef enum logic [2:0] {
    EKCI_KEY_NONE_E,
    EKCI_KEY_CHAR_E,
    EKCI_KEY_CLEAR_E,
    EKCI_KEY_LINE_CLEAR_E,
    EKCI_KEY_INTERRUPT_E,
    EKCI_KEY_NEW_LINE_E,
    EKCI_KEY_MARK_RESET_E
  } ekci_key_kind_t;

  typedef struct packed {
    logic [6:0] code;
    logic is_char;
  } ekci_key_entry_t;

  typedef struct packed {
    logic alert;
    logic audible_alarm_drive;
    logic lockout;
  } ekci_ctrl_out_t;

  typedef struct packed {
    logic alert_lamp;
    logic audible_alarm_drive;
    logic inhibit_lamp;
  } ekci_lamps_t;
endpackage : ekci_pkg

// ### design/ekci_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; clock enable freezes all state.
*/
`timescale 1ns/10ps
module ekci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } ekci_fifo_state_t;

  ekci_fifo_state_t st_ff;
  ekci_fifo_state_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign wr_ready_out = (st_ff.count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd_valid_out = (st_ff.count != '0);
  assign rd_data_out = mem[st_ff.rd_ptr];
  assign push = ce_in && wr_valid_in && wr_ready_out;
  assign pop = ce_in && rd_valid_out && rd_ready_in;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[st_ff.wr_ptr] <= wr_data_in;
    end
  end
endmodule : ekci_fifo

// ### design/ekci_encoder.sv
/*
  Key encoder: maps a key kind and character code to the seven code lines.
  Assumes a one-hot key press pulse from the keyboard matrix logic.
*/
`timescale 1ns/10ps
`include "ekci_regs.svh"
module ekci_encoder (
  input wire ekci_pkg::ekci_key_kind_t kind_in,
  input wire logic [6:0] char_in,
  output ekci_pkg::ekci_key_entry_t entry_out,
  output logic valid_out
);
  import ekci_pkg::*;

  always_comb begin
    entry_out = '0;
    valid_out = 1'b1;
    case (kind_in)
      EKCI_KEY_CHAR_E: begin
        // Only the four middle columns are real characters; others are dropped.
        valid_out = (char_in >= `EKCI_CHAR_LO) && (char_in <= `EKCI_CHAR_HI);
        entry_out.code = char_in;
        entry_out.is_char = 1'b1;
      end
      EKCI_KEY_CLEAR_E: entry_out.code = `EKCI_KEY_CLEAR;
      EKCI_KEY_LINE_CLEAR_E: entry_out.code = `EKCI_KEY_LINE_CLEAR;
      EKCI_KEY_INTERRUPT_E: entry_out.code = `EKCI_KEY_INTERRUPT;
      EKCI_KEY_NEW_LINE_E: entry_out.code = `EKCI_KEY_NEW_LINE;
      EKCI_KEY_MARK_RESET_E: entry_out.code = `EKCI_KEY_MARK_RESET;
      default: valid_out = 1'b0;
    endcase
  end
endmodule : ekci_encoder

// ### design/ekci_top.sv
/*
  Entry keyboard channel interface: builds the keyboard input word toward the
  controller and drives the keyboard lamps and audible_alarm_drive from controller outputs, deadman_expired_in and inhibit_switch_in.
  Assumes all inputs synchronous to clk_in and one key press pulse per key.
*/
`timescale 1ns/10ps
`include "ekci_regs.svh"
module ekci_top (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire ekci_pkg::ekci_key_kind_t key_kind_in,
  input wire logic [6:0] key_char_in,
  input wire logic key_press_in,
  input wire logic repeat_key_in,
  input wire logic inhibit_switch_in,
  input wire logic protect_switch_in,
  input wire logic alert_button_in,
  input wire logic [3:0] mode_switch_in,
  input wire ekci_pkg::ekci_ctrl_out_t ctrl_in,
  input wire logic deadman_expired_in,
  input wire logic word_taken_in,
  output logic [15:0] input_channel_one_out,
  output logic [3:0] mode_lines_out,
  output logic key_overflow_out,
  output ekci_pkg::ekci_lamps_t lamps_out
);
  import ekci_pkg::*;

  localparam logic [25:0] REPEAT_CYC = 26'(`EKCI_REPEAT_CYC);

  typedef enum logic [1:0] {
    EKCI_IDLE_S,
    EKCI_PRESENT_S
  } ekci_state_t;

  typedef struct packed {
    ekci_state_t state;
    logic [15:0] word;
    logic [3:0] modes;
    ekci_lamps_t lamps;
    ekci_key_entry_t last;
    logic have_last;
    logic rpt_cmd;
    logic [25:0] rpt_cnt;
    logic repeat_prev;
    logic overflow;
  } ekci_top_state_t;

  ekci_top_state_t st_ff;
  ekci_top_state_t nxt_st;

  ekci_key_entry_t enc_entry;
  logic enc_valid;
  ekci_key_entry_t fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  ekci_key_entry_t fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic repeat_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Key encoding and buffering.

  ekci_encoder u_encoder (
    .kind_in(key_kind_in),
    .char_in(key_char_in),
    .entry_out(enc_entry),
    .valid_out(enc_valid)
  );

  // A repeat slot yields to a fresh key press; the timer stays at zero, so the repeat retries on the next cycle.
  assign repeat_fire = repeat_key_in && st_ff.have_last && (st_ff.rpt_cnt == '0);
  assign fifo_in = (key_press_in && enc_valid) ? enc_entry : st_ff.last;
  assign fifo_in_valid = ce_in && ((key_press_in && enc_valid) || repeat_fire);
  // An entry is popped when it is loaded into the word, which happens only in EKCI_IDLE_S.
  assign fifo_out_ready = (st_ff.state == EKCI_IDLE_S);

  ekci_fifo #(
    .WIDTH($bits(ekci_key_entry_t)),
    .DEPTH(`EKCI_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .wr_data_in(fifo_in),
    .wr_valid_in(fifo_in_valid),
    .wr_ready_out(fifo_in_ready),
    .rd_data_out(fifo_out),
    .rd_valid_out(fifo_out_valid),
    .rd_ready_in(fifo_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_st = st_ff;
    if (ce_in) begin
      // Repeat timer counts down only while the key is held.
      nxt_st.repeat_prev = repeat_key_in;
      if (!repeat_key_in) begin
        nxt_st.rpt_cnt = '0;
      end else if (st_ff.rpt_cnt != '0) begin
        nxt_st.rpt_cnt = st_ff.rpt_cnt - 1'b1;
      end else if (repeat_fire && fifo_in_ready && !key_press_in) begin
        nxt_st.rpt_cnt = REPEAT_CYC - 1'b1;
      end
      if (repeat_key_in && !st_ff.repeat_prev && !st_ff.have_last) begin
        nxt_st.rpt_cmd = 1'b1;
      end else if (st_ff.have_last) begin
        nxt_st.rpt_cmd = 1'b0;
      end
      if (key_press_in && enc_valid) begin
        nxt_st.last = enc_entry;
        nxt_st.have_last = 1'b1;
      end
      // A press lost to a full buffer is flagged and held until reset.
      if (fifo_in_valid && !fifo_in_ready) begin
        nxt_st.overflow = 1'b1;
      end

      // Flag bits follow their sources every cycle; the code field changes
      // only when a new entry is presented, all within one edge.
      nxt_st.word[`EKCI_REPEAT_BIT] = repeat_key_in;
      nxt_st.word[`EKCI_INHIBIT_BIT] = inhibit_switch_in;
      nxt_st.word[`EKCI_PROTECT_BIT] = protect_switch_in;
      nxt_st.word[`EKCI_ALARM_DIS_BIT] = alert_button_in;
      nxt_st.word[`EKCI_RPT_CMD_BIT] = nxt_st.rpt_cmd;
      nxt_st.modes = mode_switch_in;

      case (st_ff.state)
        EKCI_IDLE_S: begin
          if (fifo_out_valid) begin
            nxt_st.word[`EKCI_CODE_MSB:`EKCI_CODE_LSB] = fifo_out.code;
            nxt_st.word[`EKCI_STROBE_BIT] = fifo_out.is_char;
            nxt_st.state = EKCI_PRESENT_S;
          end
        end
        EKCI_PRESENT_S: begin
          if (word_taken_in) begin
            nxt_st.word[`EKCI_STROBE_BIT] = 1'b0;
            nxt_st.state = EKCI_IDLE_S;
          end
        end
        default: nxt_st.state = EKCI_IDLE_S;
      endcase

      nxt_st.lamps.alert_lamp = ctrl_in.alert || deadman_expired_in;
      nxt_st.lamps.audible_alarm_drive = ctrl_in.audible_alarm_drive || deadman_expired_in;
      nxt_st.lamps.inhibit_lamp = ctrl_in.lockout || inhibit_switch_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '{state: EKCI_IDLE_S, word: `EKCI_WORD_RESET, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign input_channel_one_out = st_ff.word;
  assign mode_lines_out = st_ff.modes;
  assign key_overflow_out = st_ff.overflow;
  assign lamps_out = st_ff.lamps;
endmodule : ekci_top

// ### verification/ekci_top_properties.sv
/* Checker for the input word, mode lines and lamps of ekci_top.
   Assumes ce_in stays high, so each flag trails its input by one cycle. */
`timescale 1ns/10ps
module ekci_top_chk (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic repeat_key_in,
  input wire logic inhibit_switch_in,
  input wire logic protect_switch_in,
  input wire logic alert_button_in,
  input wire logic [3:0] mode_switch_in,
  input wire ekci_pkg::ekci_ctrl_out_t ctrl_in,
  input wire logic deadman_expired_in,
  input wire logic word_taken_in,
  input wire logic [15:0] input_channel_one_out,
  input wire logic [3:0] mode_lines_out,
  input wire ekci_pkg::ekci_lamps_t lamps_out
);
  import ekci_pkg::*;
  wire logic [15:0] w = input_channel_one_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_held; w[11] && !word_taken_in; endsequence
  sequence s_taken; w[11] && word_taken_in; endsequence
  ////////////////////////////////////////////////////////////////////////
  a_strobe_holds: assert property (s_held |=> w[11] && $stable(w[7:1])) else $error("strobe lost");
  a_strobe_drop: assert property (s_taken |=> !w[11]) else $error("strobe stuck");
  a_char_range: assert property (w[11] |-> w[7:1] >= 7'h20 && w[7:1] <= 7'h5f) else $error("bad char");
  a_spare_bits: assert property (w[0] == 1'b0 && w[8] == 1'b0 && w[15] == 1'b0) else $error("spare set");
  a_inhibit_flag: assert property (1'b1 |=> w[10] == $past(inhibit_switch_in)) else $error("bad inhibit");
  a_repeat_flag: assert property (1'b1 |=> w[9] == $past(repeat_key_in)) else $error("bad repeat");
  a_protect_level: assert property (1'b1 |=> w[12] == $past(protect_switch_in)) else $error("bad protect");
  a_alarm_disable: assert property (1'b1 |=> w[13] == $past(alert_button_in)) else $error("bad alarm");
  a_mode_follow: assert property (1'b1 |=> mode_lines_out == $past(mode_switch_in)) else $error("bad mode");
  a_alert_lamp: assert property (
    1'b1 |=> lamps_out.alert_lamp == ($past(ctrl_in.alert) || $past(deadman_expired_in)))
    else $error("bad alert lamp");
  a_audible_alarm_drive_drive: assert property (
    1'b1 |=> lamps_out.audible_alarm_drive == ($past(ctrl_in.audible_alarm_drive) || $past(deadman_expired_in)))
    else $error("bad audible_alarm_drive");
  a_inhibit_lamp: assert property (
    1'b1 |=> lamps_out.inhibit_lamp == ($past(ctrl_in.lockout) || $past(inhibit_switch_in)))
    else $error("bad inhibit lamp");
endmodule : ekci_top_chk
bind ekci_top ekci_top_chk chk_u (.*);

// ### verification/ekci_ctrl_model.sv
/* Controller model: takes presented entries off the input word.
   Assumes stall_in holds entries back and ack_req_in acks function codes. */
`timescale 1ns/10ps
module ekci_ctrl_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] word_in,
  input wire logic stall_in,
  input wire logic ack_req_in,
  output logic word_taken_out
);
  // A one-cycle pulse; never two in a row, so an ack never lands on the next entry.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) word_taken_out <= 1'b0;
    else word_taken_out <= ((word_in[11] && !stall_in) || ack_req_in) && !word_taken_out;
  end
endmodule : ekci_ctrl_model

// ### verification/entry_keyboard_channel_interface_tb.sv
/* Bench for ekci_top: keys, repeat, flags, lamps and FIFO overflow.
   Assumes the controller model acks strobed entries on its own. */
`timescale 1ns/10ps
module entry_keyboard_channel_interface_tb;
  import ekci_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, press = 0, rpt = 0, inh = 0, prot = 0, alrt = 0, dead = 0, stall = 0, areq = 0;
  logic [6:0] ch = 7'h00;
  logic [3:0] mode = 4'h0, mlines;
  logic [15:0] w;
  logic taken, ovf;
  ekci_key_kind_t kind = EKCI_KEY_NONE_E;
  ekci_ctrl_out_t ctrl = '0;
  ekci_lamps_t lamps;
  int fail_count = 0, n_compared = 0;
  ekci_key_kind_t fk[5] = '{EKCI_KEY_CLEAR_E, EKCI_KEY_LINE_CLEAR_E, EKCI_KEY_INTERRUPT_E,
    EKCI_KEY_NEW_LINE_E, EKCI_KEY_MARK_RESET_E};
  logic [6:0] fc[5] = '{7'h00, 7'h03, 7'h02, 7'h0a, 7'h1c};
  logic [6:0] cc[3] = '{7'h41, 7'h20, 7'h5f};
  always #12.5 clk = ~clk;
  ekci_top dut_u (.clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .key_kind_in(kind), .key_char_in(ch),
    .key_press_in(press), .repeat_key_in(rpt), .inhibit_switch_in(inh), .protect_switch_in(prot),
    .alert_button_in(alrt), .mode_switch_in(mode), .ctrl_in(ctrl), .deadman_expired_in(dead),
    .word_taken_in(taken), .input_channel_one_out(w), .mode_lines_out(mlines), .key_overflow_out(ovf),
    .lamps_out(lamps));
  ekci_ctrl_model ctl_u (.clk_in(clk), .arst_n_in(rst_n), .word_in(w), .stall_in(stall),
    .ack_req_in(areq), .word_taken_out(taken));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic hit(input ekci_key_kind_t k, input logic [6:0] c);
    @(negedge clk);
    {press, kind, ch} = {1'b1, k, c};
    @(negedge clk);
    press = 1'b0;
  endtask : hit
  task automatic wait_strobe();
    for (int i = 0; i < 60 && w[11] !== 1'b1; i++) @(negedge clk);
  endtask : wait_strobe
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check("reset word", w, 16'h0000);
    check("reset lamps", {13'h0, lamps}, 16'h0000);
    rpt = 1'b1;
    repeat (2) @(negedge clk);
    check("repeat cmd", {w[14], w[9]}, 16'h0003);
    rpt = 1'b0;
    foreach (cc[i]) begin
      hit(EKCI_KEY_CHAR_E, cc[i]);
      wait_strobe();
      check("char word", {w[11], w[7:1]}, {8'h01, cc[i]});
      repeat (3) @(negedge clk);
      check("strobe drop", w[11], 16'h0000);
    end
    rpt = 1'b1;
    wait_strobe();
    check("repeat code", w[7:1], 16'h005f);
    rpt = 1'b0;
    repeat (4) @(negedge clk);
    hit(EKCI_KEY_CHAR_E, 7'h60);
    repeat (4) @(negedge clk);
    check("no char", w[11], 16'h0000);
    foreach (fk[i]) begin
      hit(fk[i], 7'h00);
      repeat (3) @(negedge clk);
      check("func code", {w[11], w[7:1]}, {9'h000, fc[i]});
      areq = 1'b1;
      @(negedge clk);
      areq = 1'b0;
      repeat (3) @(negedge clk);
    end
    stall = 1'b1;
    for (int i = 0; i < 34; i++) begin
      @(negedge clk);
      {press, kind, ch} = {1'b1, EKCI_KEY_CHAR_E, 7'h30 + 7'(i)};
    end
    @(negedge clk);
    press = 1'b0;
    repeat (2) @(negedge clk);
    check("overflow", ovf, 16'h0001);
    stall = 1'b0;
    for (int k = 0; k < 32; k++) begin
      wait_strobe();
      check("drain order", w[7:1], 16'h0030 + 16'(k));
      repeat (3) @(negedge clk);
    end
    for (int i = 0; i < 16; i++) begin
      // Controller bits are rotated against the switches so each lamp source is seen alone.
      {inh, prot, alrt, dead, mode, ctrl} = {i[0], i[1], i[2], i[3], 4'(i), i[1], i[0], i[2]};
      repeat (2) @(negedge clk);
      check("flags", {w[13], w[12], w[10], mlines}, {9'h0, i[2], i[1], i[0], 4'(i)});
      check("lamps", {13'h0, lamps}, {13'h0, i[1] | i[3], i[0] | i[3], i[2] | i[0]});
    end
    wrap_up();
  end
  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : entry_keyboard_channel_interface_tb
